// >>> verilog/dpr_pkg.sv
// Constants and types shared by the dual-port memory port controller
`default_nettype none
package dpr_pkg;
  localparam int ADDR_W = 11;
  localparam int DATA_W = 8;
  localparam int TMR_W = 4;
  localparam logic [ADDR_W-1:0] MBOX_TO_LEFT = 11'h7FE;
  localparam logic [ADDR_W-1:0] MBOX_TO_RIGHT = 11'h7FF;
  localparam int CLK_PERIOD_NS = 40;
  localparam int ACCESS_NS = 120;
  localparam int WRITE_PULSE_NS = 70;
  localparam int PRIORITY_LEAD_TIME_NS = 25;
  // Least times round up to whole cycles
  localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_PULSE_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LEAD_CYC = (PRIORITY_LEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [TMR_W-1:0] ACCESS_LOAD = TMR_W'(ACCESS_CYC - 1);
  localparam logic [TMR_W-1:0] WRITE_LOAD = TMR_W'(WRITE_PULSE_CYC - 1);
  localparam logic [TMR_W-1:0] LEAD_LOAD = TMR_W'(LEAD_CYC - 1);
  localparam logic [TMR_W-1:0] TMR_ZERO = 4'h0;
  localparam logic [TMR_W-1:0] TMR_ONE = 4'h1;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_SETUP = 3'h1,
    ST_ACCESS = 3'h2,
    ST_STALL = 3'h3,
    ST_RECOVER = 3'h4
  } dpr_state_t;
endpackage
`default_nettype wire

// >>> verilog/dpr_timer.sv
// Down-counting phase timer for the memory port controller
`default_nettype none
module dpr_timer (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic load_in,
  input wire logic [dpr_pkg::TMR_W-1:0] value_in,
  output logic expired_out
);
  typedef struct packed {
    logic [dpr_pkg::TMR_W-1:0] cnt;
  } dpr_tmr_regs_t;

  dpr_tmr_regs_t r;
  dpr_tmr_regs_t next_r;

  always_comb begin
    next_r = r;
    if (load_in) begin
      next_r.cnt = value_in;
    end else if (r.cnt != dpr_pkg::TMR_ZERO) begin
      next_r.cnt = r.cnt - dpr_pkg::TMR_ONE;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign expired_out = (r.cnt == dpr_pkg::TMR_ZERO);
endmodule
`default_nettype wire

// >>> verilog/dpr_port_ctrl.sv
// Host controller that drives one port of the dual-port memory through its pins
`default_nettype none
module dpr_port_ctrl #(
  parameter logic [dpr_pkg::ADDR_W-1:0] OWN_MAILBOX = dpr_pkg::MBOX_TO_LEFT
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic req_valid_in,
  input wire logic req_write_in,
  input wire logic [dpr_pkg::ADDR_W-1:0] req_addr_in,
  input wire logic [dpr_pkg::DATA_W-1:0] req_wdata_in,
  output logic req_ready_out,
  output logic rsp_valid_out,
  output logic [dpr_pkg::DATA_W-1:0] rsp_rdata_out,
  output logic rsp_mailbox_out,
  output logic mail_pending_out,
  output logic ram_cs_n_out,
  output logic ram_we_n_out,
  output logic ram_oe_n_out,
  output logic [dpr_pkg::ADDR_W-1:0] ram_addr_out,
  input wire logic [dpr_pkg::DATA_W-1:0] ram_data_in,
  output logic [dpr_pkg::DATA_W-1:0] ram_data_out,
  output logic ram_data_oe_n_out,
  input wire logic ram_busy_n_in,
  input wire logic ram_int_n_in
);
  typedef struct packed {
    dpr_pkg::dpr_state_t state;
    logic write;
    logic [dpr_pkg::ADDR_W-1:0] addr;
    logic [dpr_pkg::DATA_W-1:0] wdata;
    logic [dpr_pkg::DATA_W-1:0] rdata;
    logic cs_n;
    logic we_n;
    logic oe_n;
    logic data_oe_n;
    logic rsp_valid;
    logic rsp_mailbox;
    logic mail_pending;
  } dpr_ctrl_regs_t;

  dpr_ctrl_regs_t r;
  dpr_ctrl_regs_t next_r;
  logic tmr_load;
  logic [dpr_pkg::TMR_W-1:0] tmr_value;
  logic tmr_expired;

  // Phase length of one strobe window, shared by first start and restart
  function automatic logic [dpr_pkg::TMR_W-1:0] access_load(input logic write);
    return write ? dpr_pkg::WRITE_LOAD : dpr_pkg::ACCESS_LOAD;
  endfunction

  dpr_timer u_timer (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .load_in(tmr_load),
    .value_in(tmr_value),
    .expired_out(tmr_expired)
  );

  always_comb begin
    next_r = r;
    tmr_load = 1'b0;
    tmr_value = dpr_pkg::LEAD_LOAD;
    next_r.rsp_valid = 1'b0;
    // Open-drain flag: low means the far port left mail
    next_r.mail_pending = ~ram_int_n_in;
    case (r.state)
      dpr_pkg::ST_IDLE: begin
        if (req_valid_in) begin
          // Address settles with select and write enable high
          next_r.addr = req_addr_in;
          next_r.write = req_write_in;
          next_r.wdata = req_wdata_in;
          next_r.state = dpr_pkg::ST_SETUP;
          tmr_load = 1'b1;
          tmr_value = dpr_pkg::LEAD_LOAD;
        end
      end
      dpr_pkg::ST_SETUP: begin
        if (tmr_expired) begin
          next_r.cs_n = 1'b0;
          next_r.oe_n = r.write;
          // No write strobe in a read cycle
          next_r.we_n = ~r.write;
          next_r.data_oe_n = ~r.write;
          next_r.state = dpr_pkg::ST_ACCESS;
          tmr_load = 1'b1;
          tmr_value = access_load(r.write);
        end
      end
      dpr_pkg::ST_ACCESS: begin
        if (!ram_busy_n_in) begin
          // Busy is our wait line; pull the strobe back so nothing lands
          next_r.we_n = 1'b1;
          next_r.state = dpr_pkg::ST_STALL;
        end else if (tmr_expired) begin
          next_r.rdata = r.write ? r.rdata : ram_data_in;
          next_r.rsp_mailbox = ~r.write && (r.addr == OWN_MAILBOX);
          // Strobes release together; data held one more cycle
          next_r.cs_n = 1'b1;
          next_r.we_n = 1'b1;
          next_r.oe_n = 1'b1;
          next_r.state = dpr_pkg::ST_RECOVER;
        end
      end
      dpr_pkg::ST_STALL: begin
        // Select and address held so our grant request stays in place
        if (ram_busy_n_in) begin
          next_r.we_n = ~r.write;
          next_r.state = dpr_pkg::ST_ACCESS;
          tmr_load = 1'b1;
          tmr_value = access_load(r.write);
        end
      end
      dpr_pkg::ST_RECOVER: begin
        next_r.data_oe_n = 1'b1;
        next_r.rsp_valid = 1'b1;
        next_r.state = dpr_pkg::ST_IDLE;
      end
      default: begin
        next_r.state = dpr_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      r <= '0;
      r.state <= dpr_pkg::ST_IDLE;
      r.cs_n <= 1'b1;
      r.we_n <= 1'b1;
      r.oe_n <= 1'b1;
      r.data_oe_n <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign req_ready_out = (r.state == dpr_pkg::ST_IDLE);
  assign rsp_valid_out = r.rsp_valid;
  assign rsp_rdata_out = r.rdata;
  assign rsp_mailbox_out = r.rsp_mailbox;
  assign mail_pending_out = r.mail_pending;
  assign ram_cs_n_out = r.cs_n;
  assign ram_we_n_out = r.we_n;
  assign ram_oe_n_out = r.oe_n;
  assign ram_addr_out = r.addr;
  assign ram_data_out = r.wdata;
  assign ram_data_oe_n_out = r.data_oe_n;

  property p_addr_held_selected;
    @(posedge clk_sys_in) disable iff (rst_in)
      (!ram_cs_n_out && !$past(ram_cs_n_out)) |-> $stable(ram_addr_out);
  endproperty
  a_addr_held_selected: assert property (p_addr_held_selected)
    else $error("address moved while selected");

  property p_addr_before_select;
    @(posedge clk_sys_in) disable iff (rst_in)
      $fell(ram_cs_n_out) |-> $stable(ram_addr_out) && $past(ram_cs_n_out, 2);
  endproperty
  a_addr_before_select: assert property (p_addr_before_select)
    else $error("select fell without prior address setup");

  property p_we_high_addr_change;
    @(posedge clk_sys_in) disable iff (rst_in)
      $changed(ram_addr_out) |-> ram_we_n_out && $past(ram_we_n_out);
  endproperty
  a_we_high_addr_change: assert property (p_we_high_addr_change)
    else $error("write enable low across address change");

  property p_no_drive_in_read;
    @(posedge clk_sys_in) disable iff (rst_in)
      (!ram_cs_n_out && !ram_oe_n_out) |-> ram_data_oe_n_out;
  endproperty
  a_no_drive_in_read: assert property (p_no_drive_in_read)
    else $error("host drives data during a read");

  property p_we_high_read;
    @(posedge clk_sys_in) disable iff (rst_in)
      (!ram_oe_n_out) |-> ram_we_n_out throughout (!ram_oe_n_out)[*1];
  endproperty
  a_we_high_read: assert property (p_we_high_read)
    else $error("write strobe in read cycle");

  property p_busy_waits;
    @(posedge clk_sys_in) disable iff (rst_in)
      (!ram_cs_n_out && !ram_busy_n_in) |=> !ram_cs_n_out && ram_we_n_out && !rsp_valid_out;
  endproperty
  a_busy_waits: assert property (p_busy_waits)
    else $error("access went on while busy");

  property p_release_resumes;
    @(posedge clk_sys_in) disable iff (rst_in)
      (r.state == dpr_pkg::ST_STALL && ram_busy_n_in) |=> r.state == dpr_pkg::ST_ACCESS ##0
        (r.write ? !ram_we_n_out : ram_we_n_out);
  endproperty
  a_release_resumes: assert property (p_release_resumes)
    else $error("access did not resume after busy release");
endmodule
`default_nettype wire

// >>> dv/dpr_mem_model.sv
// Behavioural dual-port memory: arbitration, mailboxes, open-drain flags
`default_nettype none
module dpr_mem_model (
  input wire logic [1:0] cs_n_in,
  input wire logic [1:0] we_n_in,
  input wire logic [1:0] oe_n_in,
  input wire logic [1:0][dpr_pkg::ADDR_W-1:0] addr_in,
  input wire logic [1:0][dpr_pkg::DATA_W-1:0] dout_in,
  input wire logic [1:0] doe_n_in,
  output logic [1:0][dpr_pkg::DATA_W-1:0] din_out,
  output wire logic [1:0] busy_n_out,
  output wire logic [1:0] int_n_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [dpr_pkg::DATA_W-1:0] mem [2**dpr_pkg::ADDR_W];
  logic [1:0] busy = 2'b00;
  logic [1:0] flag = 2'b00;
  realtime t [2];
  wire match = cs_n_in == 2'b00 && addr_in[0] == addr_in[1];
  initial foreach (mem[k]) mem[k] = 8'h00;
  always @(negedge cs_n_in[0] or addr_in[0]) t[0] = $realtime;
  always @(negedge cs_n_in[1] or addr_in[1]) t[1] = $realtime;
  // Short delay lets both time stamps of one instant land first
  always @(match) begin
    #0.1;
    if (!match) busy = 2'b00;
    else if (busy == 2'b00) busy = (t[0] <= t[1]) ? 2'b10 : 2'b01;
  end
  always @* begin
    for (int i = 0; i < 2; i++) begin
      if (!cs_n_in[i] && !busy[i]) begin
        if (!we_n_in[i]) begin
          mem[addr_in[i]] = dout_in[i];
          if (addr_in[i] == (i ? dpr_pkg::MBOX_TO_LEFT : dpr_pkg::MBOX_TO_RIGHT)) begin
            flag[1-i] = 1'b1;
          end
        end else if (!oe_n_in[i] && addr_in[i] == (i ? 11'h7FF : 11'h7FE)) begin
          flag[i] = 1'b0;
        end
      end
    end
  end
  // Undriven pins show the complement of the stored byte, never the stored byte
  always @* begin
    for (int i = 0; i < 2; i++) begin
      din_out[i] = !doe_n_in[i] ? dout_in[i]
        : (!cs_n_in[i] && !oe_n_in[i] && we_n_in[i] && !busy[i]) ? mem[addr_in[i]]
        : ~mem[addr_in[i]];
    end
  end
  assign busy_n_out = {busy[1] ? 1'b0 : 1'bz, busy[0] ? 1'b0 : 1'bz};
  assign int_n_out = {flag[1] ? 1'b0 : 1'bz, flag[0] ? 1'b0 : 1'bz};
endmodule
`default_nettype wire

// >>> dv/testbench.sv
// Self-checking bench: two port controllers sharing one memory model
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1;
  logic [1:0] valid = 2'b00;
  logic [1:0] wr = 2'b00;
  logic [1:0][10:0] addr = '0;
  logic [1:0][7:0] wdata = '0;
  wire logic [1:0] ready, rvalid, mbox, pend, cs_n, we_n, oe_n, doe_n;
  wire logic [1:0][7:0] rdata, dout, din;
  wire logic [1:0][10:0] ra;
  tri1 [1:0] busy_n, int_n;
  logic [9:0] notes [2][$];
  logic [9:0] n;
  logic [10:0] a;
  logic [31:0] seed = 32'd99809;
  int mismatches = 0;
  int compares = 0;
  always #20 clk_sys_in = ~clk_sys_in;
  for (genvar s = 0; s < 2; s++) begin : g_port
    dpr_port_ctrl #(
      .OWN_MAILBOX(s ? dpr_pkg::MBOX_TO_RIGHT : dpr_pkg::MBOX_TO_LEFT)
    ) i_dpr_port_ctrl (
      .clk_sys_in(clk_sys_in), .rst_in(rst_in), .req_valid_in(valid[s]), .req_write_in(wr[s]),
      .req_addr_in(addr[s]), .req_wdata_in(wdata[s]), .req_ready_out(ready[s]),
      .rsp_valid_out(rvalid[s]), .rsp_rdata_out(rdata[s]), .rsp_mailbox_out(mbox[s]),
      .mail_pending_out(pend[s]), .ram_cs_n_out(cs_n[s]), .ram_we_n_out(we_n[s]),
      .ram_oe_n_out(oe_n[s]), .ram_addr_out(ra[s]), .ram_data_in(din[s]),
      .ram_data_out(dout[s]), .ram_data_oe_n_out(doe_n[s]), .ram_busy_n_in(busy_n[s]),
      .ram_int_n_in(int_n[s]));
  end
  dpr_mem_model i_dpr_mem_model (.cs_n_in(cs_n), .we_n_in(we_n), .oe_n_in(oe_n), .addr_in(ra),
    .dout_in(dout), .doe_n_in(doe_n), .din_out(din), .busy_n_out(busy_n), .int_n_out(int_n));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input string name, input logic [9:0] seen, input logic [9:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic finish_test();
    if (mismatches == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Note holds read flag, mailbox flag and expected byte
  task automatic issue(input int s, input logic w, input logic [10:0] ad, input logic [7:0] d);
    notes[s].push_back({~w, ~w && ad == (s ? 11'h7FF : 11'h7FE), w ? 8'h00 : d});
    valid[s] = 1'b1;
    wr[s] = w;
    addr[s] = ad;
    wdata[s] = d;
    @(posedge clk_sys_in);
    #1 valid[s] = 1'b0;
  endtask
  task automatic wait_idle();
    int k = 0;
    while (notes[0].size() + notes[1].size() != 0 || ready !== 2'b11 || k < 3) begin
      @(posedge clk_sys_in);
      k++;
      if (k > 300) begin
        mismatches++;
        finish_test();
      end
    end
    #1;
  endtask
  always @(negedge clk_sys_in) begin
    for (int s = 0; s < 2; s++) begin
      if (rvalid[s] !== 1'b0) begin
        n = (notes[s].size() != 0) ? notes[s].pop_front() : 10'h3FF;
        check("response", {n[9], mbox[s], n[9] ? rdata[s] : 8'h00}, n);
      end
    end
  end
  initial begin
    repeat (16) @(posedge clk_sys_in);
    #1 rst_in = 1'b0;
    wait_idle();
    check("pending", {8'h00, pend}, 10'h000);
    for (int k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      a = seed[10:0] & 11'h7FD;
      issue(k % 2, 1'b1, a, seed[18:11]);
      wait_idle();
      issue(1 - k % 2, 1'b0, a, seed[18:11]);
      wait_idle();
    end
    for (int s = 0; s < 2; s++) begin
      seed = lfsr(seed);
      a = s ? 11'h7FF : 11'h7FE;
      issue(1 - s, 1'b1, a, seed[7:0]);
      wait_idle();
      check("pending", {8'h00, pend}, s ? 10'h002 : 10'h001);
      issue(s, 1'b0, a, seed[7:0]);
      wait_idle();
      check("pending", {8'h00, pend}, 10'h000);
    end
    seed = lfsr(seed);
    a = seed[10:0] & 11'h7FD;
    fork
      issue(0, 1'b1, a, seed[18:11]);
      issue(1, 1'b0, a, seed[18:11]);
    join
    wait_idle();
    fork
      issue(1, 1'b1, a, ~seed[18:11]);
      begin
        @(posedge clk_sys_in);
        #1 issue(0, 1'b0, a, ~seed[18:11]);
      end
    join
    wait_idle();
    finish_test();
  end
endmodule
`default_nettype wire
